// File: rmch_top.sv
`timescale 1ns/1ps
// Contract
// - the feedback speed monitor command code is 2067h in the command code field.
// - monitoring starts when the monitor command with execute request arrives.
// - the monitored value is refreshed while the execute request stays set.
// - the response echoes address, command word, status and the read value.
// - bit 14 of an axis input word starts forward continuous run for that axis.
// - the input word maps selects, start, home, stop, free, launches, inch and runs.
// - only one monitored data type per driver is supported at a time.
// - remote input data are updated by the async update command 50h, echoed back.
// - the map assumes 16 bit occupancy and 32 byte transfers.
module rmch_top
  import rmch_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // drive side feedback speed per refresh
  input wire logic [31:0] fb_speed,
  // forward run request per axis
  output logic [RMCH_AXES-1:0] fwd_run
);
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] cmd;
    logic [31:0] data;
    logic [15:0] rsp_addr;
    logic [15:0] rsp_cmd;
    logic [31:0] rsp_data;
    logic [1:0] status;
    logic [15:0] io_in;
    logic [2:0] io_axis;
    logic [7:0] io_echo;
    logic io_load;
    rmch_mon_t mon;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } rmch_state_t;
  rmch_state_t q;
  rmch_state_t next_q;
  logic [15:0] io_held [RMCH_AXES];
  logic [RMCH_AXES-1:0] fwd_w;
  logic wr;
  logic rd;
  logic exec;
  // apb access phase, one wait state
  assign wr = psel & penable & pwrite & ~q.pready;
  assign rd = psel & penable & ~pwrite & ~q.pready;
  assign exec = |(q.cmd & RMCH_EXEC_REQ);
  // register, monitor and io update machinery
  always_comb begin
    next_q = q;
    next_q.pready = psel & penable & ~q.pready;
    next_q.pslverr = 1'b0;
    next_q.io_load = 1'b0;
    if (wr) begin
      unique case (paddr)
        RMCH_A_CMD: begin
          next_q.addr = pwdata[15:0];
          next_q.cmd = pwdata[31:16];
        end
        RMCH_A_DATA: next_q.data = pwdata;
        RMCH_A_IO_IN: next_q.io_in = pwdata[15:0];
        RMCH_A_IO_CMD: begin
          if (pwdata[7:0] == RMCH_ASYNC_IO_UPDATE) begin
            next_q.io_axis = pwdata[10:8];
            next_q.io_load = 1'b1;
            next_q.io_echo = pwdata[7:0];
          end else begin
            next_q.pslverr = 1'b1;
          end
        end
        default: next_q.pslverr = 1'b1;
      endcase
    end
    // monitor machine: one item per driver, replaced on a new address
    unique case (q.mon)
      RMCH_IDLE: begin
        if (exec) begin
          next_q.rsp_addr = q.addr;
          next_q.rsp_cmd = q.cmd;
          if ((q.cmd & RMCH_CMD_MASK) == RMCH_CMD_FB_SPEED) begin
            next_q.mon = RMCH_MON;
            next_q.status = RMCH_ST_OK;
          end else begin
            next_q.mon = RMCH_DONE;
            next_q.status = RMCH_ST_BADCMD;
          end
        end
      end
      RMCH_MON: begin
        if (exec && q.addr == q.rsp_addr) begin
          next_q.rsp_data = fb_speed;
        end else begin
          next_q.mon = RMCH_IDLE;
          next_q.status = RMCH_ST_IDLE;
        end
      end
      RMCH_DONE: begin
        if (!exec) begin
          next_q.mon = RMCH_IDLE;
        end
      end
      default: next_q.mon = RMCH_IDLE;
    endcase
    // apb read data
    next_q.prdata = '0;
    if (rd) begin
      unique case (paddr)
        RMCH_A_CMD: next_q.prdata = {q.cmd, q.addr};
        RMCH_A_DATA: next_q.prdata = q.data;
        RMCH_A_RSP_CMD: next_q.prdata = {q.rsp_cmd, 14'h0, q.status};
        RMCH_A_RSP_DATA: next_q.prdata = q.rsp_data;
        RMCH_A_IO_IN: next_q.prdata = {16'h0000, q.io_in};
        RMCH_A_IO_CMD: next_q.prdata = {21'h0, q.io_axis, q.io_echo};
        RMCH_A_FB_SPEED: next_q.prdata = {16'h0000, q.rsp_addr};
        RMCH_A_RUN: next_q.prdata = {24'h000000, fwd_w};
        default: next_q.pslverr = 1'b1;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
  // one decoder per axis
  for (genvar i = 0; i < RMCH_AXES; i++) begin : g_axis
    rmch_axis_ctl u_axis (
      .pclk(pclk),
      .presetn(presetn),
      .load(q.io_load && q.io_axis == 3'(i)),
      .io_word(q.io_in),
      .fwd_run(fwd_w[i]),
      .io_held(io_held[i])
    );
  end
  // outputs come straight from state flops
  assign fwd_run = fwd_w;
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  // monitor start, refresh, stop, echo and single item; io update and apb answer timing
  a_mon_start: assert property (@(posedge pclk) disable iff (!presetn)
    q.mon == RMCH_IDLE && q.cmd == (RMCH_CMD_FB_SPEED | RMCH_EXEC_REQ)
    |=> q.mon == RMCH_MON && q.status == RMCH_ST_OK)
    else $error("monitor did not start");
  a_mon_refresh: assert property (@(posedge pclk) disable iff (!presetn)
    q.mon == RMCH_MON && exec && q.addr == q.rsp_addr
    |=> q.rsp_data == $past(fb_speed))
    else $error("monitor value not refreshed");
  a_mon_stop: assert property (@(posedge pclk) disable iff (!presetn)
    q.mon == RMCH_MON && !exec |=> q.mon == RMCH_IDLE)
    else $error("monitor did not stop");
  a_rsp_echo: assert property (@(posedge pclk) disable iff (!presetn)
    q.mon == RMCH_IDLE && exec |=> q.rsp_cmd == $past(q.cmd) && q.rsp_addr == $past(q.addr))
    else $error("command echo wrong");
  a_one_item: assert property (@(posedge pclk) disable iff (!presetn)
    q.mon == RMCH_MON && q.addr != q.rsp_addr |=> q.mon == RMCH_IDLE)
    else $error("second monitor item kept");
  a_io_update: assert property (@(posedge pclk) disable iff (!presetn)
    q.io_load |-> q.io_echo == RMCH_ASYNC_IO_UPDATE)
    else $error("io update without command");
  a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !q.pready |=> pready ##1 !pready)
    else $error("apb answer timing");
  // monitor decode and release
  a_bad_code: assert property (@(posedge pclk) disable iff (!presetn)
    q.mon == RMCH_IDLE && exec && (q.cmd & RMCH_CMD_MASK) != RMCH_CMD_FB_SPEED
    |=> q.mon == RMCH_DONE && q.status == RMCH_ST_BADCMD)
    else $error("bad command code not refused");
  a_mon_hold: assert property (@(posedge pclk) disable iff (!presetn)
    q.mon == RMCH_MON && exec && q.addr == q.rsp_addr
    |=> q.mon == RMCH_MON && q.status == RMCH_ST_OK)
    else $error("monitor dropped while requested");
  a_stop_status: assert property (@(posedge pclk) disable iff (!presetn)
    q.mon == RMCH_MON && !exec |=> q.status == RMCH_ST_IDLE)
    else $error("status not idle after stop");
  a_done_release: assert property (@(posedge pclk) disable iff (!presetn)
    q.mon == RMCH_DONE && !exec |=> q.mon == RMCH_IDLE)
    else $error("refused command not released");
  // register writes land as framed
  a_cmd_frame: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == RMCH_A_CMD |=> {q.cmd, q.addr} == $past(pwdata))
    else $error("command word not taken");
  a_data_frame: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == RMCH_A_DATA |=> q.data == $past(pwdata))
    else $error("data word not taken");
  // remote input update path
  a_io_accept: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == RMCH_A_IO_CMD && pwdata[7:0] == RMCH_ASYNC_IO_UPDATE |=> q.io_load)
    else $error("io update not taken");
  a_io_refuse: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == RMCH_A_IO_CMD && pwdata[7:0] != RMCH_ASYNC_IO_UPDATE
    |=> !q.io_load && pslverr)
    else $error("wrong io command not refused");
  a_run_steady: assert property (@(posedge pclk) disable iff (!presetn)
    !q.io_load |=> $stable(fwd_w))
    else $error("forward run changed without update");
  // bus answer shape
  a_rd_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !pready |-> prdata == 32'h0000_0000)
    else $error("read data outside answer cycle");
  a_err_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error without answer");
endmodule

// File: rmch_pkg.sv
package rmch_pkg;
  // command word fields
  localparam logic [15:0] RMCH_CMD_FB_SPEED = 16'h2067;
  localparam logic [15:0] RMCH_EXEC_REQ = 16'h4000;
  localparam logic [15:0] RMCH_CMD_MASK = 16'h3fff;
  localparam logic [7:0] RMCH_ASYNC_IO_UPDATE = 8'h50;
  // remote input bit positions
  localparam int RMCH_BIT_START = 3;
  localparam int RMCH_BIT_HOME = 4;
  localparam int RMCH_BIT_STOP = 5;
  localparam int RMCH_BIT_FREE = 6;
  localparam int RMCH_BIT_SEQ = 11;
  localparam int RMCH_BIT_INCH_POS = 12;
  localparam int RMCH_BIT_INCH_NEG = 13;
  localparam int RMCH_BIT_FWD = 14;
  localparam int RMCH_BIT_RVS = 15;
  localparam int RMCH_IO_BYTES = 32;
  localparam int RMCH_AXES = 8;
  // status codes
  localparam logic [1:0] RMCH_ST_IDLE = 2'h0;
  localparam logic [1:0] RMCH_ST_OK = 2'h1;
  localparam logic [1:0] RMCH_ST_BADCMD = 2'h2;
  // apb register map (byte addresses)
  localparam logic [7:0] RMCH_A_CMD = 8'h00;
  localparam logic [7:0] RMCH_A_DATA = 8'h04;
  localparam logic [7:0] RMCH_A_RSP_CMD = 8'h08;
  localparam logic [7:0] RMCH_A_RSP_DATA = 8'h0c;
  localparam logic [7:0] RMCH_A_IO_IN = 8'h10;
  localparam logic [7:0] RMCH_A_IO_CMD = 8'h14;
  localparam logic [7:0] RMCH_A_FB_SPEED = 8'h18;
  localparam logic [7:0] RMCH_A_RUN = 8'h1c;
  typedef enum logic [1:0] {RMCH_IDLE, RMCH_MON, RMCH_DONE} rmch_mon_t;
endpackage

// File: rmch_axis_ctl.sv
`timescale 1ns/1ps
// per-axis decode of one remote input word into the forward run request
module rmch_axis_ctl
  import rmch_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // update strobe and word
  input wire logic load,
  input wire logic [15:0] io_word,
  // decoded state
  output logic fwd_run,
  output logic [15:0] io_held
);
  typedef struct packed {
    logic fwd_run;
    logic [15:0] io_held;
  } rmch_axis_t;
  rmch_axis_t q;
  rmch_axis_t next_q;
  // forward run holds while its bit is set and no stop or free excitation
  always_comb begin
    next_q = q;
    if (load) begin
      next_q.io_held = io_word;
      next_q.fwd_run = io_word[RMCH_BIT_FWD] & ~io_word[RMCH_BIT_STOP]
                       & ~io_word[RMCH_BIT_FREE];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
  assign fwd_run = q.fwd_run;
  assign io_held = q.io_held;
  a_fwd_follow: assert property (@(posedge pclk) disable iff (!presetn)
    load && io_word == RMCH_EXEC_REQ |=> fwd_run)
    else $error("forward run not started");
endmodule

// File: rmch_net_master.sv
`timescale 1ns/1ps
// network master model: drives the register side of the handler
module rmch_net_master (
  // clock
  input wire logic pclk,
  // apb master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // one transfer; the request holds until pready is sampled high at a rising edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // values read right after the edge are the ones the edge sampled
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;  // released data must not keep its last value
  endtask
endmodule

// File: test_rmch_top.sv
`timescale 1ns/1ps
// self-checking bench for the remote monitor command handler
module test_rmch_top;
  import rmch_pkg::*;
  typedef struct packed {logic [2:0] axis; logic [15:0] word; logic forward_continuous_run;} rmch_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [31:0] fb_speed = 32'h0000_003c;
  logic [RMCH_AXES-1:0] fwd_run;
  logic [RMCH_AXES-1:0] exp_run = '0;
  int err_count = 0;
  int compares = 0;
  int cycles = 0;
  // axis, input word, forward run expected
  rmch_row_t rows [6] = '{'{3'h0, 16'h4000, 1'b1}, '{3'h3, 16'h4020, 1'b0},
    '{3'h7, 16'hc000, 1'b1}, '{3'h1, 16'h4040, 1'b0}, '{3'h5, 16'h7fbf, 1'b0},
    '{3'h0, 16'h0000, 1'b0}};

  always #2.5 pclk = ~pclk;

  // hang guard
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      finish_test();
    end
  end

  rmch_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fb_speed(fb_speed), .fwd_run(fwd_run));
  rmch_net_master i_master (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask

  task automatic finish_test();
    $display("counts: %0d compares, %0d mismatches", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (5) @(posedge pclk);
    chk_word({24'h0, fwd_run}, 32'h0);
    presetn <= 1'b1;
    $display("test reset done");
    foreach (rows[i]) begin
      i_master.xfer(1'b1, RMCH_A_IO_IN, {16'h0, rows[i].word}, rd, err);
      i_master.xfer(1'b1, RMCH_A_IO_CMD, {21'h0, rows[i].axis, 8'h50}, rd, err);
      exp_run[rows[i].axis] = rows[i].forward_continuous_run;
      @(posedge pclk);
      #1;
      chk_word({24'h0, fwd_run}, {24'h0, exp_run});
    end
    i_master.xfer(1'b0, RMCH_A_RUN, 32'h0, rd, err);
    chk_word(rd, {24'h0, exp_run});
    i_master.xfer(1'b1, RMCH_A_DATA, 32'h0000_1388, rd, err);
    chk_flag(err, 1'b0);
    i_master.xfer(1'b0, RMCH_A_DATA, 32'h0, rd, err);
    chk_word(rd, 32'h0000_1388);
    $display("test remote input map done");
    i_master.xfer(1'b1, RMCH_A_CMD, {RMCH_CMD_FB_SPEED | RMCH_EXEC_REQ, 16'h0}, rd, err);
    repeat (2) @(posedge pclk);
    i_master.xfer(1'b0, RMCH_A_RSP_CMD, 32'h0, rd, err);
    chk_word(rd, {16'h6067, 14'h0, RMCH_ST_OK});
    i_master.xfer(1'b0, RMCH_A_RSP_DATA, 32'h0, rd, err);
    chk_word(rd, 32'h0000_003c);
    fb_speed <= 32'h0000_0bb8;
    repeat (2) @(posedge pclk);
    i_master.xfer(1'b0, RMCH_A_RSP_DATA, 32'h0, rd, err);
    chk_word(rd, 32'h0000_0bb8);
    i_master.xfer(1'b1, RMCH_A_CMD, 32'h0, rd, err);
    i_master.xfer(1'b0, RMCH_A_RSP_CMD, 32'h0, rd, err);
    chk_word({30'h0, rd[1:0]}, {30'h0, RMCH_ST_IDLE});
    i_master.xfer(1'b1, RMCH_A_CMD, {16'h6067, 16'h0003}, rd, err);
    repeat (2) @(posedge pclk);
    i_master.xfer(1'b0, RMCH_A_RSP_CMD, 32'h0, rd, err);
    chk_word(rd, {16'h6067, 14'h0, RMCH_ST_OK});
    i_master.xfer(1'b0, RMCH_A_FB_SPEED, 32'h0, rd, err);
    chk_word(rd, 32'h0000_0003);
    i_master.xfer(1'b1, RMCH_A_CMD, 32'h0000_0005, rd, err);
    i_master.xfer(1'b0, RMCH_A_CMD, 32'h0, rd, err);
    chk_word(rd, 32'h0000_0005);
    i_master.xfer(1'b0, RMCH_A_RSP_CMD, 32'h0, rd, err);
    chk_word(rd, {16'h6067, 14'h0, RMCH_ST_IDLE});
    $display("test monitor done");
    i_master.xfer(1'b1, RMCH_A_CMD, {16'h4001, 16'h0}, rd, err);
    repeat (2) @(posedge pclk);
    i_master.xfer(1'b0, RMCH_A_RSP_CMD, 32'h0, rd, err);
    chk_word({30'h0, rd[1:0]}, {30'h0, RMCH_ST_BADCMD});
    i_master.xfer(1'b1, RMCH_A_CMD, 32'h0, rd, err);
    i_master.xfer(1'b0, 8'h20, 32'h0, rd, err);
    chk_flag(err, 1'b1);
    i_master.xfer(1'b1, RMCH_A_IO_CMD, 32'h0000_0051, rd, err);
    chk_flag(err, 1'b1);
    $display("test refusals done");
    // reset in mid run drops forward run and the response area
    presetn <= 1'b0;
    exp_run = '0;
    @(posedge pclk);
    #1;
    chk_word({24'h0, fwd_run}, {24'h0, exp_run});
    @(posedge pclk);
    presetn <= 1'b1;
    i_master.xfer(1'b0, RMCH_A_RSP_CMD, 32'h0, rd, err);
    chk_word(rd, 32'h0);
    i_master.xfer(1'b0, RMCH_A_RUN, 32'h0, rd, err);
    chk_word(rd, {24'h0, exp_run});
    $display("test mid reset done");
    finish_test();
  end
endmodule
